// >>> hdl/fpi_pkg.sv
// Constants, types and timing figures shared by the flash programming interface
package fpi_pkg;
   // Clock rate and derived timing
   localparam int CLK_MHZ = 100;
   localparam int WRITE_PAR_US = 50;
   localparam int WRITE_PAR_CYC = WRITE_PAR_US * CLK_MHZ;
   localparam int WRITE_SER_NS = 500000;
   localparam int WRITE_SER_CYC = WRITE_SER_NS / 10;
   localparam int ERASE_MS = 500;
   localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
   localparam int ERASE_PULSE_MIN_NS = 200;
   localparam int ERASE_PULSE_MIN_CYC = (ERASE_PULSE_MIN_NS + 9) / 10;
   localparam int BUSY_DELAY_NS = 1000;
   localparam int BUSY_DELAY_CYC = BUSY_DELAY_NS / 10;
   // Array geometry
   localparam int ADDR_W = 12;
   localparam int DEPTH = 4096;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] ERASE_READ_BYTE = 8'h00;
   // Serial instruction bytes
   localparam logic [7:0] SER_PREFIX = 8'hAC;
   localparam logic [7:0] SER_ENABLE_B2 = 8'h53;
   localparam logic [7:0] SER_ENABLE_ECHO = 8'h69;
   localparam logic [2:0] SER_ERASE_TOP = 3'h4;
   localparam logic [2:0] SER_LOCK_TOP = 3'h7;
   localparam logic [7:0] SER_READ = 8'h20;
   localparam logic [7:0] SER_WRITE = 8'h40;
   localparam logic [7:0] SER_READ_LOCK = 8'h24;
   localparam logic [7:0] SER_READ_SIG = 8'h28;
   // Parallel mode select codes {a_hi, b_hi, ctl_c, line_a, line_b}
   localparam logic [4:0] PM_WRITE = 5'h17;
   localparam logic [4:0] PM_READ = 5'h03;
   localparam logic [4:0] PM_LOCK1 = 5'h1F;
   localparam logic [4:0] PM_LOCK2 = 5'h1C;
   localparam logic [4:0] PM_LOCK3 = 5'h16;
   localparam logic [4:0] PM_READ_LOCK = 5'h1A;
   localparam logic [4:0] PM_ERASE = 5'h14;
   localparam logic [4:0] PM_SIG = 5'h00;
   // Signature addresses upper nibble
   localparam logic [3:0] SIG_MAKER = 4'h0;
   localparam logic [3:0] SIG_PART = 4'h1;
   localparam logic [3:0] SIG_REV = 4'h2;
   typedef enum {FS_IDLE, FS_WRITE, FS_ERASE} fpi_flash_state_t;
endpackage

// >>> hdl/fpi_serial_link.sv
// Serial link shifter on the shift clock: frames four-byte instructions
`timescale 1ns/100ps
`default_nettype none
module fpi_serial_link (
   input wire logic sck,
   input wire logic rst_hi,
   input wire logic mosi,
   output logic miso,
   output logic [31:0] frame,
   output logic frame_tgl,
   input wire logic [7:0] reply
);
   import fpi_pkg::*;
   logic [4:0] bit_cnt_r;
   logic [31:0] shift_r;
   logic [7:0] out_r;
   // Enable echo decided here from bytes one and two, so it lands in the same frame
   wire [7:0] reply_sel = (shift_r[23:8] == {SER_PREFIX, SER_ENABLE_B2}) ?
                          SER_ENABLE_ECHO : reply;
   // Sample on rising edge, MSB first; session held in reset while rst_hi low
   always_ff @(posedge sck or negedge rst_hi) begin
      if (!rst_hi) begin
         bit_cnt_r <= 5'h00;
         shift_r <= 32'h0;
         frame <= 32'h0;
         frame_tgl <= 1'b0;
      end else begin
         shift_r <= {shift_r[30:0], mosi};
         bit_cnt_r <= bit_cnt_r + 5'h01;
         if (bit_cnt_r == 5'h1F) begin
            frame <= {shift_r[30:0], mosi};
            frame_tgl <= ~frame_tgl;
         end
      end
   end
   // Fourth byte reply loaded at byte boundary, shifted out on falling edge
   always_ff @(negedge sck or negedge rst_hi) begin
      if (!rst_hi) begin
         out_r <= 8'h00;
      end else if (bit_cnt_r == 5'h18) begin
         out_r <= reply_sel;
      end else begin
         out_r <= {out_r[6:0], 1'b0};
      end
   end
   // Output moves only on falling edges, so the far side sees it settled at its rise
   assign miso = out_r[7];
endmodule
`default_nettype wire

// >>> hdl/fpi_sync.sv
// Two-flop synchroniser for a bundle of levels
`timescale 1ns/100ps
`default_nettype none
module fpi_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/fpi_top.sv
// Flash programming and protection logic: parallel port and serial link
// Summary of operation
// - Level 2: block internal table reads from external code, latch access pin, no programming.
// - Level 3: as level 2, and code read-back verify is refused.
// - Level 4: as level 3, and external program execution is blocked.
// - Lock bit one programmed: access pin sampled and held at reset.
// - Parallel byte write is self-timed, done within 50 us.
// - Polling the written byte during write returns bit 7 inverted.
// - Progress output goes low after strobe rises, high when write ends.
// - Code read refused only when lock bits one and two are both programmed; lock bits always readable.
// - Signature bytes at 000H, 100H, 200H with both mode lines low.
// - Serial chip erase self-timed, about 500 ms.
// - Serial reads return 00H while erasing.
// - Serial link works only while reset high; low ends the session.
// - No serial instruction accepted before programming enable.
// - Chip erase sets every byte to FFH.
// - Serial byte write self-timed, done within half a millisecond.
// - Serial read returns addressed byte on the serial output.
// - Serial polling during write returns inverted MSB.
// - Every serial instruction is four bytes.
// - Enable is AC 53 xx xx; device echoes 69 in byte four.
// - Serial erase is AC then byte with top bits 100.
// - Lock-bit read reports programmed bits as one.
`timescale 1ns/100ps
`default_nettype none
module fpi_top #(
   parameter int WRITE_PAR_CYCLES = fpi_pkg::WRITE_PAR_CYC,
   parameter int WRITE_SER_CYCLES = fpi_pkg::WRITE_SER_CYC,
   parameter int ERASE_CYCLES = fpi_pkg::ERASE_CYC,
   parameter logic [7:0] SIG_MAKER_VAL = 8'hA5, // Arbitrary value
   parameter logic [7:0] SIG_PART_VAL = 8'h3C, // Arbitrary value
   parameter logic [7:0] SIG_REV_VAL = 8'h01 // Arbitrary value
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic reset_pin,
   input wire logic [fpi_pkg::ADDR_W-1:0] par_addr,
   input wire logic [7:0] par_data_in,
   output logic [7:0] par_data_out,
   output logic par_data_oe,
   input wire logic mode_hi_a,
   input wire logic mode_hi_b,
   input wire logic mode_ctl_c,
   input wire logic mode_select_line_a,
   input wire logic mode_select_line_b,
   input wire logic read_enable_n,
   input wire logic latch_or_program_strobe,
   input wire logic access_or_program_voltage_pin,
   input wire logic program_voltage_high,
   output logic write_progress_output,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   input wire logic ext_code_fetch,
   input wire logic table_read_internal,
   output logic table_read_allowed,
   output logic external_exec_allowed,
   output logic external_access_select,
   output logic [1:0] protection_level
);
   import fpi_pkg::*;

   // Synchronised pins
   logic [ADDR_W-1:0] addr_s;
   logic [7:0] din_s;
   logic [4:0] mode_s;
   logic rd_n_s, strobe_s, vpp_s, acc_s, rst_pin_s, tgl_s, ext_s, tbl_s;
   fpi_sync #(.W(ADDR_W + 8)) u_sync_bus (
      .clk(clk), .nrst(nrst),
      .d({par_addr, par_data_in}),
      .q({addr_s, din_s})
   );
   logic frame_tgl;
   fpi_sync #(.W(13)) u_sync_ctl (
      .clk(clk), .nrst(nrst),
      .d({mode_hi_a, mode_hi_b, mode_ctl_c, mode_select_line_a, mode_select_line_b,
          read_enable_n, latch_or_program_strobe, program_voltage_high,
          access_or_program_voltage_pin, reset_pin, frame_tgl, ext_code_fetch,
          table_read_internal}),
      .q({mode_s, rd_n_s, strobe_s, vpp_s, acc_s, rst_pin_s, tgl_s, ext_s, tbl_s})
   );

   // Serial link on its own clock; frame words are stable once the toggle is seen
   logic [31:0] frame;
   logic [7:0] reply_r;
   fpi_serial_link u_link (
      .sck(sck), .rst_hi(reset_pin), .mosi(mosi), .miso(miso),
      .frame(frame), .frame_tgl(frame_tgl), .reply(reply_r)
   );

   // Storage and state
   logic [7:0] mem_r [DEPTH];
   logic [2:0] lock_r;
   fpi_flash_state_t state_r;
   logic [31:0] timer_r;
   logic [ADDR_W-1:0] last_addr_r, erase_idx_r;
   logic [7:0] last_data_r;
   logic ser_en_r, tgl_d_r, strobe_d_r, ea_latch_r;
   logic [1:0] settle_r;
   logic [7:0] erase_pulse_r;

   function automatic logic [7:0] sig_byte(input logic [3:0] hi);
      sig_byte = (hi == SIG_MAKER) ? SIG_MAKER_VAL :
                 (hi == SIG_PART) ? SIG_PART_VAL :
                 (hi == SIG_REV) ? SIG_REV_VAL : 8'h00;
   endfunction

   // Read path with polling; a byte under write reads bit 7 inverted
   function automatic logic [7:0] poll_read(input logic [ADDR_W-1:0] a,
                                            input logic [7:0] m);
      poll_read = (state_r == FS_WRITE && a == last_addr_r) ?
                  {~last_data_r[7], m[6:0]} : m;
   endfunction

   // Protection decode
   wire program_strobe_lock = lock_r[0];
   wire verify_lock = lock_r[0] & lock_r[1];
   wire exec_lock = &lock_r;
   assign protection_level = exec_lock ? 2'h3 : verify_lock ? 2'h2 : program_strobe_lock ? 2'h1 : 2'h0;
   assign table_read_allowed = ~(program_strobe_lock & ext_s & tbl_s);
   assign external_exec_allowed = ~exec_lock;
   assign external_access_select = program_strobe_lock ? ea_latch_r : acc_s;

   // Parallel decode
   // Synchroniser leaves reset low while the strobe idles high: ignore edges until it fills
   wire strobe_rise = strobe_s & ~strobe_d_r & (settle_r == 2'h3);
   wire par_idle = (state_r == FS_IDLE);
   wire par_write_go = strobe_rise && vpp_s && mode_s == PM_WRITE && par_idle && !program_strobe_lock;
   wire [2:0] lock_set = !(strobe_rise && vpp_s && par_idle) ? 3'h0 :
                         (mode_s == PM_LOCK1) ? 3'h1 :
                         (mode_s == PM_LOCK2) ? 3'h2 :
                         (mode_s == PM_LOCK3) ? 3'h4 : 3'h0;
   wire par_erase_go = strobe_rise && vpp_s && mode_s == PM_ERASE && par_idle &&
                       erase_pulse_r >= 8'(ERASE_PULSE_MIN_CYC);
   wire [7:0] par_rd = (mode_s == PM_READ) ? (verify_lock ? 8'h00 :
                                              poll_read(addr_s, mem_r[addr_s])) :
                       (mode_s == PM_READ_LOCK) ? {3'h0, lock_r, 2'h0} :
                       (mode_s == PM_SIG) ? sig_byte(addr_s[11:8]) : 8'h00;

   // Serial decode
   wire frame_new = (tgl_s != tgl_d_r) && rst_pin_s;
   wire is_enable = frame[31:24] == SER_PREFIX && frame[23:16] == SER_ENABLE_B2;
   wire is_erase = ser_en_r && frame[31:24] == SER_PREFIX && frame[23:21] == SER_ERASE_TOP;
   wire is_lockw = ser_en_r && frame[31:24] == SER_PREFIX && frame[23:21] == SER_LOCK_TOP;
   wire is_write = ser_en_r && frame[31:24] == SER_WRITE;
   wire [ADDR_W-1:0] ser_addr = frame[19:8];
   wire ser_write_go = frame_new && is_write && par_idle && !program_strobe_lock;
   wire ser_erase_go = frame_new && is_erase && par_idle;

   // Reply for the next frame's fourth byte, prepared from the command bytes
   logic [7:0] reply_nxt;
   always_comb begin
      reply_nxt = 8'h00;
      if (state_r == FS_ERASE) begin
         reply_nxt = ERASE_READ_BYTE;
      end else if (frame[31:24] == SER_READ && ser_en_r && !verify_lock) begin
         reply_nxt = poll_read(ser_addr, mem_r[ser_addr]);
      end else if (frame[31:24] == SER_READ_LOCK && ser_en_r) begin
         reply_nxt = {3'h0, lock_r, 2'h0};
      end else if (frame[31:24] == SER_READ_SIG && ser_en_r) begin
         reply_nxt = sig_byte(frame[11:8]);
      end
   end

   // Edge trackers, reset latch and enable state
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tgl_d_r <= 1'b0;
         strobe_d_r <= 1'b0;
         settle_r <= 2'h0;
         ea_latch_r <= 1'b0;
         ser_en_r <= 1'b0;
         erase_pulse_r <= 8'h00;
      end else begin
         tgl_d_r <= tgl_s;
         strobe_d_r <= strobe_s;
         if (settle_r != 2'h3) begin
            settle_r <= settle_r + 2'h1;
         end
         if (rst_pin_s) begin
            ea_latch_r <= acc_s;
         end
         if (!rst_pin_s) begin
            ser_en_r <= 1'b0;
         end else if (frame_new && is_enable) begin
            ser_en_r <= 1'b1;
         end
         erase_pulse_r <= strobe_s ? 8'h00 :
                          (erase_pulse_r == 8'hFF ? 8'hFF : erase_pulse_r + 8'h01);
      end
   end

   // Reply register, sampled by the link only at its byte-four boundary
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reply_r <= 8'h00;
      end else begin
         reply_r <= reply_nxt;
      end
   end

   // Flash sequencer: self-timed writes and erases
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r <= FS_IDLE;
         timer_r <= 32'h0;
         last_addr_r <= '0;
         last_data_r <= 8'h00;
         erase_idx_r <= '0;
         lock_r <= 3'h0;
      end else begin
         lock_r <= lock_r | lock_set;
         if (frame_new && is_lockw && par_idle) begin
            lock_r <= lock_r | lock_set | {frame[9:8] == 2'h3, frame[9], |frame[9:8]};
         end
         case (state_r)
            FS_IDLE: begin
               if (par_write_go || ser_write_go) begin
                  state_r <= FS_WRITE;
                  timer_r <= par_write_go ? 32'(WRITE_PAR_CYCLES) : 32'(WRITE_SER_CYCLES);
                  last_addr_r <= par_write_go ? addr_s : ser_addr;
                  last_data_r <= par_write_go ? din_s : frame[7:0];
               end else if (par_erase_go || ser_erase_go) begin
                  state_r <= FS_ERASE;
                  timer_r <= 32'(ERASE_CYCLES);
                  erase_idx_r <= '0;
               end
            end
            FS_WRITE: begin
               timer_r <= timer_r - 32'h1;
               if (timer_r == 32'h1) begin
                  state_r <= FS_IDLE;
               end
            end
            default: begin
               timer_r <= timer_r - 32'h1;
               if (erase_idx_r != '1) begin
                  erase_idx_r <= erase_idx_r + 1'b1;
               end
               if (timer_r == 32'h1) begin
                  state_r <= FS_IDLE;
                  lock_r <= 3'h0;
               end
            end
         endcase
      end
   end

   // Array storage; write commits at end of self-timed cycle, erase walks the array
   always_ff @(posedge clk) begin
      if (state_r == FS_WRITE && timer_r == 32'h1) begin
         mem_r[last_addr_r] <= last_data_r;
      end else if (state_r == FS_ERASE) begin
         mem_r[erase_idx_r] <= ERASED_BYTE;
      end
   end

   // Parallel outputs
   always_ff @(posedge clk) begin
      if (!nrst) begin
         par_data_out <= 8'h00;
         par_data_oe <= 1'b0;
         write_progress_output <= 1'b1;
      end else begin
         par_data_out <= par_rd;
         par_data_oe <= rst_pin_s & ~rd_n_s & strobe_s;
         write_progress_output <= par_idle & ~par_write_go;
      end
   end

   // Age of the running write; too long for a delay range, so it is counted
   logic [31:0] wr_age_r;
   logic wr_par_r;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_age_r <= 32'h0;
         wr_par_r <= 1'b0;
      end else begin
         wr_age_r <= (state_r == FS_WRITE) ? wr_age_r + 32'h1 : 32'h0;
         if (par_idle) begin
            wr_par_r <= par_write_go;
         end
      end
   end

   // Busy must fall within a fixed bound of the strobe's rise
   AST_BUSY_AFTER_STROBE: assert property (@(posedge clk) disable iff (!nrst)
      par_write_go |=> !write_progress_output)
      else $error("progress output not low after write strobe");
   AST_WRITE_TIME: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == FS_WRITE && wr_par_r) |-> wr_age_r < 32'(WRITE_PAR_CYCLES))
      else $error("parallel write overran");
   AST_LOCKED_NO_WRITE: assert property (@(posedge clk) disable iff (!nrst)
      (program_strobe_lock && par_idle) |=> state_r != FS_WRITE)
      else $error("write started while locked");
   AST_VERIFY_BLOCK: assert property (@(posedge clk) disable iff (!nrst)
      (verify_lock && mode_s == PM_READ) |=> par_data_out == 8'h00)
      else $error("code read while verify locked");
   AST_EXEC_BLOCK: assert property (@(posedge clk) disable iff (!nrst)
      exec_lock |-> !external_exec_allowed && protection_level == 2'h3)
      else $error("external execution allowed at level 4");
   AST_ERASE_REPLY: assert property (@(posedge clk) disable iff (!nrst)
      state_r == FS_ERASE |=> reply_r == 8'h00)
      else $error("nonzero serial read during erase");
   AST_SESSION_END: assert property (@(posedge clk) disable iff (!nrst)
      !rst_pin_s |=> !ser_en_r)
      else $error("session outlived reset low");
   AST_ENABLE_FIRST: assert property (@(posedge clk) disable iff (!nrst)
      (!ser_en_r && par_idle && !par_write_go && !par_erase_go) |=> par_idle)
      else $error("serial command ran before enable");
endmodule
`default_nettype wire

// >>> tb/fpi_isp_program_strobe.sv
// Serial programmer model: drives the shift clock and data, collects the device reply
`timescale 1ns/100ps
`default_nettype none
module fpi_isp_program_strobe #(
   parameter int HALF = 96
) (
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   // Shift clock stands low between frames
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
   end
   // One four-byte instruction, MSB first; kept slower than clk/16 at the cost of run time
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      #13.7;
      for (int i = 31; i >= 0; i--) begin
         mosi = tx[i];
         #(HALF) rx[i] = miso;
         sck = 1'b1;
         #(HALF) sck = 1'b0;
      end
      // A released data line must not look like a held bit
      mosi = ~mosi;
      #300;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the flash programming interface
`timescale 1ns/100ps
`default_nettype none
module tb;
   import fpi_pkg::*;
   localparam int WPC = 60;
   localparam int WSC = 2000;
   localparam int ERC = 4200;
   // Identity codes: arbitrary values
   localparam logic [7:0] SIG_A = 8'h5A;
   localparam logic [7:0] SIG_B = 8'hC3;
   localparam logic [7:0] SIG_C = 8'h10;
   logic clk, nrst, reset_pin, rd_n, strobe, acc_pin, vpp_hi, ext_fetch, tbl_int;
   logic [ADDR_W-1:0] addr;
   logic [7:0] din, dout, d;
   logic [4:0] mode;
   logic oe, busy_n, sck, mosi, miso, tbl_ok, ext_ok, acc_sel;
   logic [1:0] lvl;
   logic [31:0] rx;
   int bad_count, tests_run;

   // Shortened timing so the run stays brief
   fpi_top #(.WRITE_PAR_CYCLES(WPC), .WRITE_SER_CYCLES(WSC), .ERASE_CYCLES(ERC),
      .SIG_MAKER_VAL(SIG_A), .SIG_PART_VAL(SIG_B), .SIG_REV_VAL(SIG_C)) fpi_top_i (
      .clk(clk), .nrst(nrst), .reset_pin(reset_pin), .par_addr(addr),
      .par_data_in(din), .par_data_out(dout), .par_data_oe(oe),
      .mode_hi_a(mode[4]), .mode_hi_b(mode[3]), .mode_ctl_c(mode[2]),
      .mode_select_line_a(mode[1]), .mode_select_line_b(mode[0]),
      .read_enable_n(rd_n), .latch_or_program_strobe(strobe),
      .access_or_program_voltage_pin(acc_pin), .program_voltage_high(vpp_hi),
      .write_progress_output(busy_n), .sck(sck), .mosi(mosi), .miso(miso),
      .ext_code_fetch(ext_fetch), .table_read_internal(tbl_int),
      .table_read_allowed(tbl_ok), .external_exec_allowed(ext_ok),
      .external_access_select(acc_sel), .protection_level(lvl));

   fpi_isp_program_strobe fpi_isp_program_strobe_i (.sck(sck), .mosi(mosi), .miso(miso));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Parallel programming cycle: setup first, then voltage, then one strobe
   task automatic pw(input logic [4:0] m, input logic [ADDR_W-1:0] a, input logic [7:0] v);
      addr = a;
      din = v;
      mode = m;
      @(negedge clk);
      vpp_hi = 1'b1;
      repeat (4) @(negedge clk);
      strobe = 1'b0;
      repeat (30) @(negedge clk);
      strobe = 1'b1;
      // Voltage held past the strobe so the synchronised take still sees it
      repeat (6) @(negedge clk);
      vpp_hi = 1'b0;
   endtask

   // Parallel read: result lands in d
   task automatic pr(input logic [4:0] m, input logic [ADDR_W-1:0] a);
      vpp_hi = 1'b0;
      addr = a;
      mode = m;
      rd_n = 1'b0;
      repeat (6) @(negedge clk);
      d = dout;
      chk(oe, 1'b1);
      rd_n = 1'b1;
      @(negedge clk);
   endtask

   task automatic t_par_write(input logic [ADDR_W-1:0] a, input logic [7:0] v);
      int n;
      n = 0;
      pw(PM_WRITE, a, v);
      chk(busy_n, 1'b0);
      pr(PM_READ, a);
      chk(d[7], !v[7]);
      while (busy_n !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk(n <= WPC, 1'b1);
      chk(busy_n, 1'b1);
      pr(PM_READ, a);
      chk(d, v);
   endtask

   task automatic t_sig();
      pr(PM_SIG, {SIG_MAKER, 8'h00});
      chk(d, SIG_A);
      pr(PM_SIG, {SIG_PART, 8'h00});
      chk(d, SIG_B);
      pr(PM_SIG, {SIG_REV, 8'h00});
      chk(d, SIG_C);
   endtask

   // Each reply arrives in byte four of the following frame; the enable echo arrives in byte four of its own frame
   task automatic t_serial();
      fpi_isp_program_strobe_i.xfer(32'h4001_2377, rx);
      fpi_isp_program_strobe_i.xfer(32'hAC53_0000, rx);
      chk(rx[7:0], SER_ENABLE_ECHO);
      fpi_isp_program_strobe_i.xfer(32'h2001_2300, rx);
      fpi_isp_program_strobe_i.xfer(32'h4002_003C, rx);
      chk(rx[7:0], 8'hA5);
      fpi_isp_program_strobe_i.xfer(32'h2002_0000, rx);
      fpi_isp_program_strobe_i.xfer(32'h2002_0000, rx);
      chk(rx[7], 1'b1);
      repeat (WSC) @(negedge clk);
      fpi_isp_program_strobe_i.xfer(32'h2002_0000, rx);
      fpi_isp_program_strobe_i.xfer(32'hAC80_0000, rx);
      chk(rx[7:0], 8'h3C);
      fpi_isp_program_strobe_i.xfer(32'h2001_2300, rx);
      fpi_isp_program_strobe_i.xfer(32'h2001_2300, rx);
      chk(rx[7:0], ERASE_READ_BYTE);
      repeat (ERC) @(negedge clk);
      fpi_isp_program_strobe_i.xfer(32'h2001_2300, rx);
      fpi_isp_program_strobe_i.xfer(32'h2001_2300, rx);
      chk(rx[7:0], ERASED_BYTE);
      fpi_isp_program_strobe_i.xfer(32'h2800_0100, rx);
      fpi_isp_program_strobe_i.xfer(32'h2400_0000, rx);
      chk(rx[7:0], SIG_B);
      fpi_isp_program_strobe_i.xfer(32'h2001_2300, rx);
      chk(rx[7:0], 8'h00);
   endtask

   task automatic t_locks();
      ext_fetch = 1'b1;
      tbl_int = 1'b1;
      chk(ext_ok, 1'b1);
      pw(PM_LOCK1, '0, '0);
      repeat (WPC + 20) @(negedge clk);
      chk(lvl, 2'd1);
      chk(tbl_ok, 1'b0);
      pw(PM_WRITE, 12'h055, 8'h00);
      chk(busy_n, 1'b1);
      pr(PM_READ, 12'h055);
      chk(d, 8'h5A);
      pw(PM_LOCK2, '0, '0);
      repeat (WPC + 20) @(negedge clk);
      chk(lvl, 2'd2);
      pr(PM_READ, 12'h055);
      chk(d, 8'h00);
      chk(ext_ok, 1'b1);
      pw(PM_LOCK3, '0, '0);
      repeat (WPC + 20) @(negedge clk);
      chk(lvl, 2'd3);
      chk(ext_ok, 1'b0);
      chk(tbl_ok, 1'b0);
      pr(PM_READ_LOCK, '0);
      chk(d, 8'h1C);
      // Session ends, then the access pin moves: the latched level must hold
      reset_pin = 1'b0;
      repeat (4) @(negedge clk);
      acc_pin = 1'b0;
      repeat (4) @(negedge clk);
      chk(acc_sel, 1'b1);
      acc_pin = 1'b1;
      reset_pin = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   task automatic t_perase();
      pw(PM_ERASE, '0, '0);
      repeat (ERC + 50) @(negedge clk);
      chk(lvl, 2'd0);
      pr(PM_READ, 12'h055);
      chk(d, ERASED_BYTE);
   endtask

   // Guard against a hang well beyond the expected run
   initial begin
      #500000;
      bad_count++;
      $display("ERROR t=%0t watchdog expired", $time);
      end_sim();
   end

   initial begin
      bad_count = 0;
      tests_run = 0;
      nrst = 1'b0;
      reset_pin = 1'b0;
      rd_n = 1'b1;
      strobe = 1'b1;
      acc_pin = 1'b1;
      vpp_hi = 1'b0;
      ext_fetch = 1'b0;
      tbl_int = 1'b0;
      addr = '0;
      din = '0;
      mode = PM_READ;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      reset_pin = 1'b1;
      repeat (10) @(negedge clk);
      chk(busy_n, 1'b1);
      chk(oe, 1'b0);
      chk(lvl, 2'd0);
      t_par_write(12'h123, 8'hA5);
      t_sig();
      t_serial();
      t_par_write(12'h055, 8'h5A);
      t_locks();
      t_perase();
      reset_pin = 1'b0;
      repeat (5) @(negedge clk);
      chk(miso, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
